/* File: design/acr_pkg.sv */
// Constants for the converter configuration and calibration register bank.
// Assumes a single 250 MHz master clock and a serial host link that is
// sampled as a plain input.
package acr_pkg;
   // ***************************************************
   // Register addresses
   // ***************************************************
   localparam logic [7:0] ADDR_CONFIG    = 8'h01;
   localparam logic [7:0] ADDR_OFS_LOW   = 8'h02;
   localparam logic [7:0] ADDR_OFS_MID   = 8'h03;
   localparam logic [7:0] ADDR_OFS_HIGH  = 8'h04;
   localparam logic [7:0] ADDR_GAIN_LOW  = 8'h05;
   localparam logic [7:0] ADDR_GAIN_HIGH = 8'h06;
   localparam logic [7:0] ADDR_MODE      = 8'h07;
   // ***************************************************
   // Field positions and masks
   // ***************************************************
   localparam int BIT_GAIN_EN     = 5;
   localparam int BIT_OFS_EN      = 4;
   localparam int BIT_TOUT_LEN    = 3;
   localparam int BIT_TOUT_EN     = 2;
   localparam int BIT_STAT_DIS    = 1;
   localparam int BIT_STAT_SEL    = 0;
   localparam logic [7:0] CONFIG_WMASK = 8'h3F;
   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] RST_CONFIG    = 8'h00;
   localparam logic [7:0] RST_OFS       = 8'h00;
   localparam logic [7:0] RST_GAIN_LOW  = 8'h00;
   localparam logic [7:0] RST_GAIN_HIGH = 8'h80;
   // ***************************************************
   // Widths and timing
   // ***************************************************
   localparam int DATA_BITS   = 24;
   localparam int STATUS_BITS = 8;
   localparam int TOUT_LONG   = 65536;  // 2^16 master clocks
   localparam int TOUT_SHORT  = 16384;  // 2^14 master clocks
   localparam int TOUT_W      = 17;
   // Filter codes
   localparam logic [1:0] FILT_WB1  = 2'h0;
   localparam logic [1:0] FILT_WB2  = 2'h1;
   localparam logic [1:0] FILT_LL   = 2'h2;
   localparam logic [1:0] FILT_RSV  = 2'h3;
endpackage

/* File: design/acr_regbank.sv */
// Register bank: a byte-wide SPI-mode slave (CPOL 0, CPHA 0), config,
// calibration and pin mirror. Assumes pins are asynchronous to sys_clk_i.
// Frame: byte 0 = {rd, 7'addr}, byte 1 = write data or read data out.
`timescale 1ns/1ps
module acr_regbank
   import acr_pkg::*;
#(
   parameter int TOUT_LONG_P  = acr_pkg::TOUT_LONG,
   parameter int TOUT_SHORT_P = acr_pkg::TOUT_SHORT
) (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // Serial host pins
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   output logic             dout_o,
   output logic             dout_oe_o,
   // Mode-select pins
   input  wire logic        resolution_select_i,
   input  wire logic [1:0]  oversampling_ratio_i,
   input  wire logic [1:0]  filter_select_i,
   input  wire logic        interface_format_i,
   input  wire logic        frame_sync_role_i,
   // Settings to the datapath
   output logic             gain_correct_enable_o,
   output logic             offset_correct_enable_o,
   output logic [23:0]      offset_calib_value_o,
   output logic [15:0]      gain_calib_value_o,
   output logic             status_word_enable_o,
   output logic             status_content_select_o,
   output logic [11:0]      oversampling_value_o,
   output logic             idle_timeout_o
);
   import acr_pkg::*;

   // ***************************************************
   // Input synchronisers
   // ***************************************************
   logic [7:0] meta_q;
   logic [7:0] sync_q;
   logic       sclk_prev_q;
   // Two flops per pin; only the second stage is read by logic
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 8'h00;
         sync_q <= 8'h00;
      end else begin
         meta_q <= {frame_sync_role_i, interface_format_i, filter_select_i,
                    oversampling_ratio_i, resolution_select_i, 1'b0};
         sync_q <= meta_q;
      end
   end
   logic [2:0] smeta_q;
   logic [2:0] ssync_q;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         smeta_q <= 3'h2;
         ssync_q <= 3'h2;
      end else begin
         smeta_q <= {din_i, cs_n_i, sclk_i};
         ssync_q <= smeta_q;
      end
   end
   wire sclk_s = ssync_q[0];
   wire cs_n_s = ssync_q[1];
   wire din_s  = ssync_q[2];
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) sclk_prev_q <= 1'b0;
      else       sclk_prev_q <= sclk_s;
   end
   wire sclk_rise = sclk_s & ~sclk_prev_q;
   wire sclk_fall = ~sclk_s & sclk_prev_q;

   // ***************************************************
   // Pin mirror
   // ***************************************************
   // Live pin levels, bit 7 always zero
   logic [7:0] mode_rd;
   assign mode_rd = {1'b0, sync_q[1], sync_q[3:2], sync_q[5:4],
                     sync_q[6], sync_q[7]};
   wire spi_mode = ~mode_rd[1];

   // Ratio decode depends on the filter family
   always_comb begin
      oversampling_value_o = 12'h020;
      case (mode_rd[3:2])
         FILT_LL: begin
            case (mode_rd[5:4])
               2'h0:    oversampling_value_o = 12'h020;
               2'h1:    oversampling_value_o = 12'h080;
               2'h2:    oversampling_value_o = 12'h200;
               default: oversampling_value_o = 12'h800;
            endcase
         end
         FILT_WB1, FILT_WB2: begin
            case (mode_rd[5:4])
               2'h0:    oversampling_value_o = 12'h020;
               2'h1:    oversampling_value_o = 12'h040;
               2'h2:    oversampling_value_o = 12'h080;
               default: oversampling_value_o = 12'h100;
            endcase
         end
         default: oversampling_value_o = 12'h000; // Reserved filter
      endcase
   end

   // ***************************************************
   // Idle timeout
   // ***************************************************
   logic [TOUT_W-1:0] idle_cnt_q;
   logic [TOUT_W-1:0] idle_lim;
   logic              cfg_tout_len;
   logic              cfg_tout_en;
   // Length choice, counted in master clocks
   assign idle_lim = cfg_tout_len ? TOUT_W'(TOUT_SHORT_P)
                                  : TOUT_W'(TOUT_LONG_P);
   // Counts only while a frame is open and sclk does not move
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         idle_cnt_q <= '0;
      end else if (cs_n_s || sclk_rise || sclk_fall || !cfg_tout_en) begin
         idle_cnt_q <= '0; // Disabled timer never fires
      end else if (idle_cnt_q != idle_lim) begin
         idle_cnt_q <= idle_cnt_q + 1'b1;
      end
   end
   assign idle_timeout_o = cfg_tout_en && (idle_cnt_q == idle_lim);

   // ***************************************************
   // Serial shifter
   // ***************************************************
   logic [7:0] shift_q;
   logic [7:0] cmd_q;
   logic [7:0] rdata_q;
   logic [3:0] bit_cnt_q;
   logic       phase_q;
   logic       wr_stb_q;
   logic [7:0] rd_mux;
   wire        frame_rst = cs_n_s | idle_timeout_o;
   wire [7:0]  shift_nx  = {shift_q[6:0], din_s};

   // Sample on rising sclk; two bytes per frame
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_q   <= 8'h00;
         cmd_q     <= 8'h00;
         bit_cnt_q <= 4'h0;
         phase_q   <= 1'b0;
         wr_stb_q  <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         if (frame_rst) begin
            bit_cnt_q <= 4'h0;
            phase_q   <= 1'b0;
         end else if (sclk_rise) begin
            shift_q <= shift_nx;
            if (bit_cnt_q == 4'h7) begin
               bit_cnt_q <= 4'h0;
               if (!phase_q) begin
                  cmd_q   <= shift_nx;
                  phase_q <= 1'b1;
               end else begin
                  // No access outside serial port mode
                  wr_stb_q <= ~cmd_q[7] & spi_mode;
                  phase_q  <= 1'b0;
               end
            end else begin
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end
         end
      end
   end

   // Read data loaded after the command byte, shifted on falling sclk
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (frame_rst) begin
         rdata_q <= 8'h00;
      end else if (sclk_rise && !phase_q && bit_cnt_q == 4'h7) begin
         rdata_q <= spi_mode ? rd_mux : 8'h00;
      end else if (sclk_fall && phase_q && bit_cnt_q != 4'h0) begin
         rdata_q <= {rdata_q[6:0], 1'b0};
      end
   end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dout_o    <= 1'b0;
         dout_oe_o <= 1'b0;
      end else begin
         dout_o    <= rdata_q[7];
         dout_oe_o <= ~cs_n_s & spi_mode & phase_q & cmd_q[7];
      end
   end

   // ***************************************************
   // Registers
   // ***************************************************
   logic [7:0] config_q;
   logic [7:0] ofs_lo_q;
   logic [7:0] ofs_mid_q;
   logic [7:0] ofs_hi_q;
   logic [7:0] gain_lo_q;
   logic [7:0] gain_hi_q;
   wire  [6:0] wr_addr = cmd_q[6:0];
   // Writable bytes; upper config bits and mode are read-only
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         config_q  <= RST_CONFIG;
         ofs_lo_q  <= RST_OFS;
         ofs_mid_q <= RST_OFS;
         ofs_hi_q  <= RST_OFS;
         gain_lo_q <= RST_GAIN_LOW;
         gain_hi_q <= RST_GAIN_HIGH;
      end else if (wr_stb_q) begin
         case ({1'b0, wr_addr})
            ADDR_CONFIG:    config_q  <= shift_q & CONFIG_WMASK;
            ADDR_OFS_LOW:   ofs_lo_q  <= shift_q;
            ADDR_OFS_MID:   ofs_mid_q <= shift_q;
            ADDR_OFS_HIGH:  ofs_hi_q  <= shift_q;
            ADDR_GAIN_LOW:  gain_lo_q <= shift_q;
            ADDR_GAIN_HIGH: gain_hi_q <= shift_q;
            default: ;      // Mode and unmapped writes dropped
         endcase
      end
   end

   // Read multiplexer, unmapped reads return zero
   always_comb begin
      // Address from the byte being completed; cmd_q is still stale here
      case ({1'b0, shift_nx[6:0]})
         ADDR_CONFIG:    rd_mux = config_q;
         ADDR_OFS_LOW:   rd_mux = ofs_lo_q;
         ADDR_OFS_MID:   rd_mux = ofs_mid_q;
         ADDR_OFS_HIGH:  rd_mux = ofs_hi_q;
         ADDR_GAIN_LOW:  rd_mux = gain_lo_q;
         ADDR_GAIN_HIGH: rd_mux = gain_hi_q;
         ADDR_MODE:      rd_mux = mode_rd;
         default:        rd_mux = 8'h00;
      endcase
   end

   // ***************************************************
   // Settings outputs
   // ***************************************************
   assign cfg_tout_len = config_q[BIT_TOUT_LEN];
   assign cfg_tout_en  = config_q[BIT_TOUT_EN];
   assign gain_correct_enable_o   = config_q[BIT_GAIN_EN];
   assign offset_correct_enable_o = config_q[BIT_OFS_EN];
   assign offset_calib_value_o = {ofs_hi_q, ofs_mid_q, ofs_lo_q};
   assign gain_calib_value_o   = {gain_hi_q, gain_lo_q};
   // Disable bit honoured only in serial port mode
   assign status_word_enable_o =
      ~(config_q[BIT_STAT_DIS] & spi_mode);
   assign status_content_select_o = config_q[BIT_STAT_SEL];

   // ***************************************************
   // Checks
   // ***************************************************
   chk_gain_reset: assert property (@(posedge sys_clk_i)
      $rose(!rst_i) |-> gain_calib_value_o == 16'h8000)
      else $error("gain reset value wrong");
   chk_cfg_upper_zero: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) config_q[7:6] == 2'h0)
      else $error("config reserved bits set");
   chk_mode_follow: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) mode_rd[6] == sync_q[1] && mode_rd[7] == 1'b0)
      else $error("mode bit 6 not pin");
   chk_status_fs: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) !spi_mode |-> status_word_enable_o)
      else $error("status dropped in frame-sync");
   chk_no_write_fs: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) wr_stb_q |-> $past(spi_mode))
      else $error("write outside serial mode");
   chk_tout_off: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) !cfg_tout_en |-> !idle_timeout_o)
      else $error("timeout while disabled");
   chk_tout_len: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) idle_timeout_o |->
      idle_cnt_q == (cfg_tout_len ? TOUT_W'(TOUT_SHORT_P)
                                  : TOUT_W'(TOUT_LONG_P)))
      else $error("timeout length wrong");
   chk_ll_ratio: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) mode_rd[3:2] == FILT_LL && mode_rd[5:4] == 2'h3
      |-> oversampling_value_o == 12'h800)
      else $error("low latency ratio wrong");

   // ***************************************************
   // Frame checks
   // ***************************************************
   // Last rising sclk of the command byte, frame still open
   sequence seq_cmd_end;
      sclk_rise && !frame_rst && !phase_q && bit_cnt_q == 4'h7;
   endsequence
   // Last rising sclk of the data byte, frame still open
   sequence seq_data_end;
      sclk_rise && !frame_rst && phase_q && bit_cnt_q == 4'h7;
   endsequence
   // Write strobe aimed at the read-only mode location
   sequence seq_mode_write;
      wr_stb_q && ({1'b0, wr_addr} == ADDR_MODE);
   endsequence
   // Write strobe aimed at the configuration byte
   sequence seq_cfg_write;
      wr_stb_q && ({1'b0, wr_addr} == ADDR_CONFIG);
   endsequence
   // Idle limit reached while a frame is open
   sequence seq_idle_hit;
      idle_timeout_o;
   endsequence
   chk_strobe_gate: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) seq_data_end |=>
      wr_stb_q == (!$past(cmd_q[7]) && $past(spi_mode)))
      else $error("write strobe gating wrong");
   chk_read_gate: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) seq_cmd_end ##0 !spi_mode |=>
      rdata_q == 8'h00)
      else $error("read data loaded in frame-sync");
   chk_mode_wr_drop: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) seq_mode_write |=> $stable(config_q) &&
      $stable(offset_calib_value_o) && $stable(gain_calib_value_o))
      else $error("mode write changed a register");
   chk_cfg_wr_mask: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) seq_cfg_write |=>
      config_q == ($past(shift_q) & CONFIG_WMASK))
      else $error("config write not masked");
   chk_idle_abort: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) seq_idle_hit |=>
      bit_cnt_q == 4'h0 && !phase_q && rdata_q == 8'h00)
      else $error("idle timeout left frame open");
   chk_fs_no_drive: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) !spi_mode |=> !dout_oe_o)
      else $error("data driven in frame-sync");
   chk_wb_ratio: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) mode_rd[3] == 1'b0 && mode_rd[5:4] == 2'h3
      |-> oversampling_value_o == 12'h100)
      else $error("wideband ratio wrong");
   chk_offset_reset: assert property (@(posedge sys_clk_i)
      $rose(!rst_i) |-> offset_calib_value_o == 24'h000000 &&
      config_q == RST_CONFIG)
      else $error("offset reset value wrong");
   chk_status_spi: assert property (@(posedge sys_clk_i)
      disable iff (rst_i) spi_mode |->
      status_word_enable_o == !config_q[BIT_STAT_DIS])
      else $error("status disable bit ignored");
endmodule

/* File: testbench/acr_host_model.sv */
// Host model: byte frames on the serial pins, one register per frame.
// Assumes the device samples din on rising and shifts dout on falling.
`timescale 1ns/1ps
module acr_host_model (
   // Clock and device outputs
   input  wire logic       sys_clk_i,
   input  wire logic       dout_i,
   input  wire logic       dout_oe_i,
   // Host pins and result
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic            din_o,
   output logic            done_o,
   output logic [8:0]      rdata_o
);
   // Serial clock parked low between frames
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o = 1'b0;
      done_o = 1'b0;
      rdata_o = 9'h000;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   // Released data line toggles so a stale bit never looks valid
   task automatic cs(input logic v);
      cs_n_o = v;
      din_o = ~din_o;
      tick(6);
   endtask
   // Frame {rd, addr}, data; 24 ns half period; oe seen is bit 8
   task automatic xfer(input logic rd, input logic [6:0] a,
                       input logic [7:0] wd);
      logic [15:0] sh;
      sh = {rd, a, wd};
      rdata_o = 9'h000;
      cs(1'b0);
      for (int i = 15; i >= 0; i--) begin
         din_o = sh[i];
         tick(6);
         rdata_o = {rdata_o[8] | dout_oe_i, rdata_o[6:0],
                    dout_oe_i & dout_i};
         sclk_o = 1'b1;
         tick(6);
         sclk_o = 1'b0;
      end
      tick(6);
      cs(1'b1);
      done_o = rd;
      tick(1);
      done_o = 1'b0;
   endtask
endmodule

/* File: testbench/test_acr_regbank.sv */
// Bench for the register bank: frames, pin sweeps, refusals, timeout.
// Assumes acr_host_model on the serial pins and short timeout counts.
`timescale 1ns/1ps
module test_acr_regbank;
   import acr_pkg::*;
   // ******************
   // Signals and queue
   // ******************
   logic        sys_clk_i, rst_i, sclk, cs_n, din, dout, dout_oe, done;
   logic        res_sel, ifc_fmt, role, obs_v, gain_en, ofs_en;
   logic        stat_en, stat_sel, tout;
   logic [1:0]  ratio_pins, filt;
   logic [8:0]  rdata;
   logic [11:0] ratio_val;
   logic [15:0] gain_val;
   logic [23:0] ofs_val, obs, exp_v, got;
   logic [31:0] seed;
   logic [7:0]  cfg;
   logic [7:0]  cal [8];
   logic [23:0] q [$];
   int          fail_count, compares;
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   acr_regbank #(.TOUT_LONG_P(64), .TOUT_SHORT_P(16)) dut_u (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk_i(sclk),
      .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
      .resolution_select_i(res_sel), .oversampling_ratio_i(ratio_pins),
      .filter_select_i(filt), .interface_format_i(ifc_fmt),
      .frame_sync_role_i(role), .gain_correct_enable_o(gain_en),
      .offset_correct_enable_o(ofs_en), .offset_calib_value_o(ofs_val),
      .gain_calib_value_o(gain_val), .status_word_enable_o(stat_en),
      .status_content_select_o(stat_sel),
      .oversampling_value_o(ratio_val), .idle_timeout_o(tout));
   acr_host_model host_u (
      .sys_clk_i(sys_clk_i), .dout_i(dout), .dout_oe_i(dout_oe),
      .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .done_o(done),
      .rdata_o(rdata));
   // Oldest note against each result as it appears
   always @(posedge sys_clk_i) begin
      if (done | obs_v) begin
         exp_v = q.pop_front();
         got = done ? {15'h0000, rdata} : obs;
         compares++;
         if (got !== exp_v) begin
            $display("Error at %0t: got %0h expected %0h", $time, got,
                     exp_v);
            fail_count++;
         end
      end
   end
   // ******************
   // Helpers
   // ******************
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk(input logic [23:0] e, input logic [23:0] g);
      q.push_back(e);
      obs = g;
      obs_v = 1'b1;
      step(1);
      obs_v = 1'b0;
      // Let an edge pass so a following call never re-raises at once
      step(1);
   endtask
   task automatic rd(input logic [6:0] a, input logic [8:0] e);
      q.push_back({15'h0000, e});
      host_u.xfer(1'b1, a, 8'h00);
   endtask
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Decoded ratio; the reserved filter code gives none
   function automatic logic [11:0] ratio(input logic [1:0] f,
                                         input logic [1:0] o);
      if (f == 2'h3) return 12'h000;
      return (f == 2'h2) ? 12'h020 << (2 * o) : 12'h020 << o;
   endfunction
   task automatic tally_and_finish();
      if (fail_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Cut a hang short; the run needs about 16k clocks
   initial begin
      #200000;
      fail_count++;
      tally_and_finish();
   end
   // ******************
   // Main sequence
   // ******************
   initial begin
      {rst_i, ifc_fmt} = 2'b10;
      {obs_v, obs, fail_count, compares} = '0;
      seed = 32'hC98CF0A6;
      {res_sel, role, ratio_pins, filt} = seed[5:0];
      step(4);
      rst_i = 1'b0;
      step(4);
      // Reset contents, then random calibration bytes
      for (int a = 1; a < 7; a++)
         rd(a[6:0], a == 6 ? 9'h180 : 9'h100);
      for (int a = 2; a < 7; a++) begin
         seed = nxt(seed);
         cal[a] = seed[7:0];
         host_u.xfer(1'b0, a[6:0], cal[a]);
      end
      for (int a = 2; a < 7; a++) rd(a[6:0], {1'b1, cal[a]});
      chk({cal[4], cal[3], cal[2]}, ofs_val);
      chk({8'h00, cal[6], cal[5]}, {8'h00, gain_val});
      // Settings; timeout enable kept off so frames never abort
      for (int i = 0; i < 8; i++) begin
         seed = nxt(seed);
         cfg = (i == 0) ? 8'hFB : (i == 1) ? 8'h00 : seed[7:0] & 8'hFB;
         host_u.xfer(1'b0, 7'h01, cfg);
         rd(7'h01, {1'b1, cfg & 8'h3F});
         chk({20'h00000, cfg[5], cfg[4], ~cfg[1], cfg[0]},
             {20'h00000, gain_en, ofs_en, stat_en, stat_sel});
      end
      // Every filter and ratio code; mode writes must not stick
      for (int i = 0; i < 16; i++) begin
         seed = nxt(seed);
         {res_sel, role} = seed[1:0];
         {filt, ratio_pins} = i[3:0];
         step(4);
         host_u.xfer(1'b0, 7'h07, seed[15:8]);
         rd(7'h07, {2'b10, res_sel, ratio_pins, filt, 1'b0, role});
         chk({12'h000, ratio(filt, ratio_pins)}, {12'h000, ratio_val});
      end
      // Frame-sync mode: no access, status word forced on
      host_u.xfer(1'b0, 7'h01, 8'h02);
      chk(24'h000000, {23'h000000, stat_en});
      ifc_fmt = 1'b1;
      step(4);
      chk(24'h000001, {23'h000000, stat_en});
      host_u.xfer(1'b0, 7'h02, ~cal[2]);
      rd(7'h02, 9'h000);
      ifc_fmt = 1'b0;
      step(4);
      rd(7'h02, {1'b1, cal[2]});
      // Idle serial clock: long limit 64, short 16, then disabled
      host_u.xfer(1'b0, 7'h01, 8'h04);
      host_u.cs(1'b0);
      step(34);
      chk(24'h000000, {23'h000000, tout});
      step(40);
      chk(24'h000001, {23'h000000, tout});
      host_u.cs(1'b1);
      host_u.xfer(1'b0, 7'h01, 8'h0C);
      host_u.cs(1'b0);
      step(34);
      chk(24'h000001, {23'h000000, tout});
      host_u.cs(1'b1);
      host_u.xfer(1'b0, 7'h01, 8'h08);
      host_u.cs(1'b0);
      step(100);
      chk(24'h000000, {23'h000000, tout});
      host_u.cs(1'b1);
      // Reset in mid-run: contents back to reset values, pins seen again
      seed = nxt(seed);
      {res_sel, role} = seed[1:0];
      rst_i = 1'b1;
      step(2);
      rst_i = 1'b0;
      step(3);
      rd(7'h06, 9'h180);
      rd(7'h02, 9'h100);
      rd(7'h07, {2'b10, res_sel, ratio_pins, filt, 1'b0, role});
      chk(24'h008000, {8'h00, gain_val});
      tally_and_finish();
   end
endmodule
